/* File: shared/ums_consts.svh */
// Timing figures, report codes and reset values for the upset mitigation sequencer
`ifndef UMS_CONSTS_SVH
`define UMS_CONSTS_SVH
// Reference clocks (MHz)
`define UMS_REF_MHZ        100
`define UMS_REF_SSI_MHZ    70
// Correction state figures (us), non-stacked then stacked-die
`define UMS_REP1_US        610
`define UMS_REP2U_US       25
`define UMS_ENH1_US        610
`define UMS_ENH2C_US       18790
`define UMS_ENH2U_US       9110
`define UMS_REPL_US        830
`define UMS_REP1_SSI_US    915
`define UMS_REP2U_SSI_US   70
`define UMS_ENH1_SSI_US    910
`define UMS_ENH2C_SSI_US   26900
`define UMS_ENH2U_SSI_US   13010
`define UMS_REPL_SSI_US    1220
// Quick exits and classification figures (us)
`define UMS_QUICK_US       10
`define UMS_CLS_US         750
`define UMS_CLS_SSI_US     1090
// Report layout
`define UMS_RPT_LEN        3
`define UMS_TAG_CORR       8'h43
`define UMS_TAG_CLS        8'h4b
`define UMS_CNT_W          21
`define UMS_STATUS_RST     1'b0
`endif

/* File: shared/ums_pkg.sv */
// Types shared by the upset mitigation sequencer
package ums_pkg;
  typedef enum logic [1:0] {UMS_REPAIR, UMS_ENHANCED, UMS_REPLACE} ums_mode_t;
  typedef enum logic [1:0] {UMS_ONE_BIT, UMS_TWO_BIT, UMS_STORE_FAULT, UMS_CRC_ONLY} ums_err_t;
  typedef enum {UMS_OBSERVE, UMS_CORRECT, UMS_CORR_RPT, UMS_CLASSIFY, UMS_CLS_RPT} ums_state_t;
endpackage

/* File: rtl/ums_sequencer.sv */
// Post-detection correction and classification sequencer with report buffer
`timescale 1ns/100ps
`default_nettype none
`include "ums_consts.svh"
module ums_sequencer #(
  parameter int unsigned REP1_CYC      = `UMS_REP1_US * `UMS_REF_MHZ,
  parameter int unsigned ENH1_CYC      = `UMS_ENH1_US * `UMS_REF_MHZ,
  parameter int unsigned ENH2C_CYC     = `UMS_ENH2C_US * `UMS_REF_MHZ,
  parameter int unsigned ENH2U_CYC     = `UMS_ENH2U_US * `UMS_REF_MHZ,
  parameter int unsigned REPL_CYC      = `UMS_REPL_US * `UMS_REF_MHZ,
  parameter int unsigned CLS_CYC       = `UMS_CLS_US * `UMS_REF_MHZ,
  parameter int unsigned REP1_SSI_CYC  = `UMS_REP1_SSI_US * `UMS_REF_SSI_MHZ,
  parameter int unsigned REP2U_SSI_CYC = `UMS_REP2U_SSI_US * `UMS_REF_SSI_MHZ,
  parameter int unsigned ENH1_SSI_CYC  = `UMS_ENH1_SSI_US * `UMS_REF_SSI_MHZ,
  parameter int unsigned ENH2C_SSI_CYC = `UMS_ENH2C_SSI_US * `UMS_REF_SSI_MHZ,
  parameter int unsigned ENH2U_SSI_CYC = `UMS_ENH2U_SSI_US * `UMS_REF_SSI_MHZ,
  parameter int unsigned REPL_SSI_CYC  = `UMS_REPL_SSI_US * `UMS_REF_SSI_MHZ,
  parameter int unsigned CLS_SSI_CYC   = `UMS_CLS_SSI_US * `UMS_REF_SSI_MHZ
) (
  input  wire logic              core_clk,        // System clock, 40 MHz
  input  wire logic              resetn,          // Async reset, active low
  input  wire logic              detectPulse,     // Scan engine found an error
  input  wire logic              eccFlag,         // Frame ECC flagged the error
  input  wire logic              multiBit,        // ECC saw more than one bit
  input  wire logic              dblRepairable,   // Enhanced checksum can fix two bits
  input  wire logic              storeFault,      // checksum_store_fault seen
  input  wire logic              essentialBit,    // Upset lies in an essential bit
  input  wire ums_pkg::ums_mode_t corrMode,       // Configured correction mode
  input  wire logic              classifyEn,      // Classification enabled
  input  wire logic              stackedDie,      // Stacked-die timing set
  input  wire logic              monFull,         // Monitor transmit FIFO full
  output logic                   detectReady,     // Sequencer accepts a detection
  output logic                   stCorrecting,    // In correction state
  output logic                   stClassifying,   // In classification state
  output logic                   stCorrectable,   // Last error was corrected
  output logic                   stEssential,     // Last error was essential
  output logic [7:0]             monData,         // Report byte to monitor
  output logic                   monValid         // Report byte valid
);
  import ums_pkg::*;

  localparam int unsigned REP2U_CYC = `UMS_REP2U_US * `UMS_REF_MHZ;
  localparam int unsigned QUICK_CYC = `UMS_QUICK_US * `UMS_REF_MHZ;
  localparam int unsigned QUICK_SSI_CYC = `UMS_QUICK_US * `UMS_REF_SSI_MHZ;
  localparam logic [1:0] LAST_IDX = 2'(`UMS_RPT_LEN - 1);

  ums_state_t                 state_r;
  ums_state_t                 state_nxt;
  ums_err_t                   errType_r;
  ums_mode_t                  mode_r;
  logic                       ssi_r;
  logic                       clsEn_r;
  logic                       ess_r;
  logic                       fixable_r;
  logic [`UMS_CNT_W-1:0]      cnt_r;
  logic [1:0]                 idx_r;
  logic [7:0]                 skidData_r;
  logic                       skidValid_r;
  logic                       rptValid;
  logic [7:0]                 rptData;
  logic                       push;
  logic                       lastPush;
  logic                       outFree;
  ums_err_t                   errNow;

  // Error kind from the check results; a store fault wins, otherwise anything ECC misses is CRC-only
  always_comb begin
    if (storeFault) begin
      errNow = UMS_STORE_FAULT;
    end else if (!eccFlag) begin
      errNow = UMS_CRC_ONLY;
    end else if (multiBit) begin
      errNow = UMS_TWO_BIT;
    end else begin
      errNow = UMS_ONE_BIT;
    end
  end

  function automatic logic canFix(ums_mode_t m, ums_err_t e, logic dbl);
    logic r;
    r = 1'b0;
    case (e)
      UMS_ONE_BIT:     r = 1'b1;
      UMS_TWO_BIT:     r = (m == UMS_REPLACE) || ((m == UMS_ENHANCED) && dbl);
      UMS_STORE_FAULT: r = (m == UMS_REPLACE);
      default:         r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [`UMS_CNT_W-1:0] sz(int unsigned v);
    return `UMS_CNT_W'(v);
  endfunction

  // Fixed correction durations; real latency scales with the clock
  function automatic logic [`UMS_CNT_W-1:0] corrCyc(ums_mode_t m, ums_err_t e, logic ok,
                                                   logic ssi);
    logic [`UMS_CNT_W-1:0] r;
    r = ssi ? sz(QUICK_SSI_CYC) : sz(QUICK_CYC);
    if (e != UMS_CRC_ONLY && !(e == UMS_STORE_FAULT && m != UMS_REPLACE)) begin
      case (m)
        UMS_REPLACE: r = ssi ? sz(REPL_SSI_CYC) : sz(REPL_CYC);
        UMS_ENHANCED: begin
          if (e == UMS_ONE_BIT) begin
            r = ssi ? sz(ENH1_SSI_CYC) : sz(ENH1_CYC);
          end else if (ok) begin
            r = ssi ? sz(ENH2C_SSI_CYC) : sz(ENH2C_CYC);
          end else begin
            r = ssi ? sz(ENH2U_SSI_CYC) : sz(ENH2U_CYC);
          end
        end
        default: begin
          if (e == UMS_ONE_BIT) begin
            r = ssi ? sz(REP1_SSI_CYC) : sz(REP1_CYC);
          end else begin
            r = ssi ? sz(REP2U_SSI_CYC) : sz(REP2U_CYC);
          end
        end
      endcase
    end
    return r;
  endfunction

  // Long pass only when corrected and enabled
  function automatic logic [`UMS_CNT_W-1:0] clsCyc(logic ok, logic en, logic ssi);
    logic [`UMS_CNT_W-1:0] r;
    if (ok && en) begin
      r = ssi ? sz(CLS_SSI_CYC) : sz(CLS_CYC);
    end else begin
      r = ssi ? sz(QUICK_SSI_CYC) : sz(QUICK_CYC);
    end
    return r;
  endfunction

  // Report bytes: tag, kind and mode, outcome
  always_comb begin
    rptValid = (state_r == UMS_CORR_RPT) || (state_r == UMS_CLS_RPT);
    case (idx_r)
      2'h0:    rptData = (state_r == UMS_CORR_RPT) ? `UMS_TAG_CORR : `UMS_TAG_CLS;
      2'h1:    rptData = {2'h0, ssi_r, clsEn_r, 2'(mode_r), 2'(errType_r)};
      default: rptData = {6'h00, ess_r, fixable_r};
    endcase
  end

  assign push     = rptValid && !skidValid_r;
  assign lastPush = push && (idx_r == LAST_IDX);
  assign outFree  = !monValid || !monFull;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      UMS_OBSERVE:  if (detectPulse) state_nxt = UMS_CORRECT;
      UMS_CORRECT:  if (cnt_r == sz(1)) state_nxt = UMS_CORR_RPT;
      UMS_CORR_RPT: if (lastPush) state_nxt = UMS_CLASSIFY;
      UMS_CLASSIFY: if (cnt_r == sz(1)) state_nxt = UMS_CLS_RPT;
      UMS_CLS_RPT:  if (lastPush) state_nxt = UMS_OBSERVE;
      default:      state_nxt = UMS_OBSERVE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= UMS_OBSERVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Capture the error as it is accepted
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      errType_r <= UMS_ONE_BIT;
      mode_r    <= UMS_REPAIR;
      ssi_r     <= 1'b0;
      clsEn_r   <= 1'b0;
      ess_r     <= 1'b0;
      fixable_r <= 1'b0;
    end else if (state_r == UMS_OBSERVE && detectPulse) begin
      errType_r <= errNow;
      mode_r    <= corrMode;
      ssi_r     <= stackedDie;
      clsEn_r   <= classifyEn;
      fixable_r <= canFix(corrMode, errNow, dblRepairable);
      // Without a corrected, classified error it must count as essential
      ess_r     <= !(canFix(corrMode, errNow, dblRepairable) && classifyEn)
                   || essentialBit;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (state_r == UMS_OBSERVE && detectPulse) begin
      cnt_r <= corrCyc(corrMode, errNow, canFix(corrMode, errNow, dblRepairable),
                       stackedDie);
    end else if (state_r == UMS_CORR_RPT && lastPush) begin
      cnt_r <= clsCyc(fixable_r, clsEn_r, ssi_r);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - sz(1);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idx_r <= 2'h0;
    end else if (lastPush) begin
      idx_r <= 2'h0;
    end else if (push) begin
      idx_r <= idx_r + 2'h1;
    end
  end

  // Flags change only as their state is left
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stCorrectable <= `UMS_STATUS_RST;
      stEssential   <= `UMS_STATUS_RST;
    end else begin
      if (state_r == UMS_CORR_RPT && lastPush) stCorrectable <= fixable_r;
      if (state_r == UMS_CLS_RPT && lastPush) stEssential <= ess_r;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      detectReady   <= 1'b1;
      stCorrecting  <= 1'b0;
      stClassifying <= 1'b0;
    end else begin
      detectReady   <= (state_nxt == UMS_OBSERVE);
      stCorrecting  <= (state_nxt == UMS_CORRECT) || (state_nxt == UMS_CORR_RPT);
      stClassifying <= (state_nxt == UMS_CLASSIFY) || (state_nxt == UMS_CLS_RPT);
    end
  end

  // Two-entry buffer: output stage plus skid; a full monitor stalls the sequencer
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      monData  <= 8'h00;
      monValid <= 1'b0;
    end else if (outFree) begin
      if (skidValid_r) begin
        monData  <= skidData_r;
        monValid <= 1'b1;
      end else begin
        monData  <= rptData;
        monValid <= push;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      skidData_r  <= 8'h00;
      skidValid_r <= 1'b0;
    end else if (skidValid_r) begin
      if (outFree) skidValid_r <= 1'b0;
    end else if (push && !outFree) begin
      skidData_r  <= rptData;
      skidValid_r <= 1'b1;
    end
  end

endmodule // ums_sequencer
`default_nettype wire

/* File: testbench/ums_sequencer_properties.sv */
// Port-level checker for the upset mitigation sequencer
`timescale 1ns/100ps
`default_nettype none
module ums_sequencer_checker (
  input wire logic               core_clk,      // Clock
  input wire logic               resetn,        // Reset, active low
  input wire logic               detectPulse,   // Error detected
  input wire logic               eccFlag,       // ECC flagged the error
  input wire logic               multiBit,      // Several bits upset
  input wire logic               dblRepairable, // Two bits fixable
  input wire logic               storeFault,    // Checksum store fault
  input wire logic               essentialBit,  // Essential location
  input wire logic               classifyEn,    // Classification on
  input wire logic               stackedDie,    // Stacked-die timing
  input wire logic               monFull,       // Monitor FIFO full
  input wire logic               detectReady,   // Ready for a detection
  input wire logic               stCorrecting,  // Correcting
  input wire logic               stClassifying, // Classifying
  input wire logic               stCorrectable, // Correctable flag
  input wire logic               stEssential,   // Essential flag
  input wire logic               monValid,      // Report byte valid
  input wire ums_pkg::ums_mode_t corrMode,      // Correction mode
  input wire logic [7:0]         monData        // Report byte
);
  import ums_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  int corrCnt;
  int clsCnt;
  // Quick classification plus a stalled report stays within 1100 cycles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) clsCnt <= 0;
    else clsCnt <= stClassifying ? clsCnt + 1 : 0;
  end
  // Correction, a stalled report included, stays within 2700 cycles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) corrCnt <= 0;
    else corrCnt <= stCorrecting ? corrCnt + 1 : 0;
  end
  AST_ACCEPT: assert property (detectReady && detectPulse |=> !detectReady && stCorrecting)
    else $error("detection not taken");
  AST_REFUSE: assert property (stCorrecting && detectPulse |=> !detectReady)
    else $error("detection taken while busy");
  AST_CORR_FLAG: assert property ($changed(stCorrectable) |-> $rose(stClassifying))
    else $error("correctable flag moved outside correction exit");
  AST_ESS_FLAG: assert property ($changed(stEssential) |-> $rose(detectReady))
    else $error("essential flag moved outside classification exit");
  AST_HOLD: assert property (monValid && monFull |=> monValid && $stable(monData))
    else $error("report byte lost under full");
  AST_ORDER: assert property ($fell(stCorrecting) |-> stClassifying)
    else $error("correction not followed by classification");
  AST_RETURN: assert property ($fell(stClassifying) |-> detectReady)
    else $error("no return to observation");
  AST_CLS_BOUND: assert property (clsCnt <= 1100)
    else $error("classification too long");
  AST_CORR_BOUND: assert property (corrCnt <= 2700)
    else $error("correction too long");
endmodule // ums_sequencer_checker
bind ums_sequencer ums_sequencer_checker u_chk (.*);
`default_nettype wire

/* File: testbench/ums_monitor_model.sv */
// Monitor serial adapter model with a shallow transmit FIFO
`timescale 1ns/100ps
`default_nettype none
module ums_monitor_model #(
  parameter int DEPTH   = 2,
  parameter int BIT_CYC = 2
) (
  input wire logic       core_clk, // Clock
  input wire logic       resetn,   // Reset, active low
  input wire logic       slow,     // Small FIFO that can fill
  input wire logic [7:0] monData,  // Byte in
  input wire logic       monValid, // Byte valid
  output logic           monFull   // FIFO full
);
  logic [7:0] rxq[$];
  int         fill;
  int         tick;
  assign monFull = slow && fill >= DEPTH;
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fill <= 0;
      tick <= 0;
    end else begin
      if (monValid && !monFull) rxq.push_back(monData);
      // One byte leaves per ten bit times
      tick <= (fill > 0 && tick < 10 * BIT_CYC - 1) ? tick + 1 : 0;
      fill <= fill + (monValid && !monFull) - (fill > 0 && tick == 10 * BIT_CYC - 1);
    end
  end
endmodule // ums_monitor_model
`default_nettype wire

/* File: testbench/ums_sequencer_tb.sv */
// Random and corner-case bench for the upset mitigation sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ums_consts.svh"
module ums_sequencer_tb;
  import ums_pkg::*;
  localparam int REP1 = 40, ENH1 = 44, ENH2C = 60, ENH2U = 52, REPL = 48, CLS = 56;
  localparam int D = 4, REP2US = 30;
  logic core_clk, resetn, detectPulse, eccFlag, multiBit, dblRepairable, storeFault;
  logic essentialBit, classifyEn, stackedDie, slow, monFull, detectReady, stCorrecting;
  logic stClassifying, stCorrectable, stEssential, monValid;
  logic [7:0] monData;
  ums_mode_t corrMode;
  int err_total, comparisons, cyc, n, seed = 26391;
  logic [31:0] r;
  ums_sequencer #(.REP1_CYC(REP1), .ENH1_CYC(ENH1), .ENH2C_CYC(ENH2C), .ENH2U_CYC(ENH2U),
    .REPL_CYC(REPL), .CLS_CYC(CLS), .REP1_SSI_CYC(REP1 - D), .REP2U_SSI_CYC(REP2US),
    .ENH1_SSI_CYC(ENH1 - D), .ENH2C_SSI_CYC(ENH2C - D), .ENH2U_SSI_CYC(ENH2U - D),
    .REPL_SSI_CYC(REPL - D), .CLS_SSI_CYC(CLS - D)) u_dut (.*);
  ums_monitor_model u_mon (.*);
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task summarize();
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task step();
    @(posedge core_clk);
    #2;
  endtask
  function automatic int typ();
    return storeFault ? 2 : !eccFlag ? 3 : multiBit ? 1 : 0;
  endfunction
  function automatic bit ok();
    int t;
    t = typ();
    return t != 3 && (corrMode == UMS_REPLACE || t == 0 ||
      (t == 1 && corrMode == UMS_ENHANCED && dblRepairable));
  endfunction
  // Zero marks paths whose count is not a parameter here
  function automatic int corrCyc();
    int t;
    t = typ();
    if (t == 3) return 0;
    if (corrMode == UMS_REPLACE) return REPL - D * stackedDie;
    if (t == 0) return (corrMode == UMS_REPAIR ? REP1 : ENH1) - D * stackedDie;
    if (t == 1 && corrMode == UMS_ENHANCED)
      return (dblRepairable ? ENH2C : ENH2U) - D * stackedDie;
    return (t == 1 && stackedDie) ? REP2US : 0;
  endfunction
  function automatic bit inTime(int e, int c, int lim);
    return e ? (c >= e && c <= e + 8) : c <= lim;
  endfunction
  task runErr();
    int k;
    logic [7:0] b1;
    logic [1:0] t;
    logic ess;
    t = 2'(typ());
    ess = !(ok() && classifyEn) || essentialBit;
    b1 = {2'b00, stackedDie, classifyEn, corrMode, t};
    detectPulse = 1;
    step();
    step();
    step();
    detectPulse = 0;
    n = 2;
    while (stCorrecting && n < 3000) begin
      step();
      n++;
    end
    check("correctable", stCorrectable, ok());
    if (!slow) check("corrTime", inTime(corrCyc(), n, 2600), 1);
    n = 0;
    while (stClassifying && n < 3000) begin
      step();
      n++;
    end
    check("essential", stEssential, ess);
    check("ready", detectReady, 1);
    if (!slow) check("clsTime", inTime(ok() && classifyEn ? CLS - D * stackedDie : 0, n, 1010), 1);
    k = 0;
    while (u_mon.rxq.size() < 6 && k < 400) begin
      step();
      k++;
    end
    check("bytes", u_mon.rxq.size(), 6);
    check("tag0", u_mon.rxq[0], `UMS_TAG_CORR);
    check("info0", u_mon.rxq[1], b1);
    check("res0", u_mon.rxq[2] & 8'h01, ok());
    check("tag1", u_mon.rxq[3], `UMS_TAG_CLS);
    check("info1", u_mon.rxq[4], b1);
    check("res1", u_mon.rxq[5], {6'h00, ess, ok()});
    u_mon.rxq.delete();
  endtask
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    {detectPulse, eccFlag, multiBit, dblRepairable, storeFault, essentialBit} = '0;
    {classifyEn, stackedDie, slow, resetn} = '0;
    corrMode = UMS_REPAIR;
    repeat (16) @(posedge core_clk);
    #2 resetn = 1;
    for (int i = 0; i < 18; i++) begin
      r = $random(seed);
      corrMode = ums_mode_t'(i % 3);
      {eccFlag, multiBit, dblRepairable, storeFault, essentialBit, classifyEn, stackedDie} = r[6:0];
      // Clean one-bit then CRC-only errors in every mode first
      if (i < 6) {storeFault, eccFlag, multiBit} = {1'b0, i < 3, 1'b0};
      slow = i >= 12;
      step();
      runErr();
    end
    detectPulse = 1;
    step();
    detectPulse = 0;
    repeat (5) step();
    resetn = 0;
    step();
    check("rstReady", detectReady, 1);
    check("rstCorr", {stCorrecting, stCorrectable, monValid}, 0);
    repeat (15) step();
    resetn = 1;
    step();
    u_mon.rxq.delete();
    {eccFlag, storeFault, multiBit, slow} = 4'h8;
    runErr();
    summarize();
  end
endmodule // ums_sequencer_tb
`default_nettype wire
